// file: src/sui_pkg.sv
// constants shared by the serial channel design files
package sui_pkg;
    // mode field codes
    localparam logic [2:0] MODE_OFF   = 3'h0;
    localparam logic [2:0] MODE_SYNC  = 3'h1;
    localparam logic [2:0] MODE_I2C   = 3'h2;
    localparam logic [2:0] MODE_UART7 = 3'h4;
    localparam logic [2:0] MODE_UART8 = 3'h5;
    localparam logic [2:0] MODE_UART9 = 3'h6;
    // character lengths
    localparam int LEN7 = 7;
    localparam int LEN8 = 8;
    localparam int LEN9 = 9;
    // oversampling per bit in uart mode
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID  = 4'h7;
    // sda delay counter ceiling and minimum setting
    localparam int MAX_DELAY = 8;
    localparam int MIN_DELAY = 2;
    // flow control type codes
    localparam logic FLOW_CTS = 1'b0;
    localparam logic FLOW_RTS = 1'b1;
    // clock source direction
    localparam logic CLK_INTERNAL = 1'b0;
    // counter reset value
    localparam logic [7:0] CNT_ZERO = 8'h00;
    typedef enum logic [1:0] {SUI_IDLE, SUI_START, SUI_DATA, SUI_STOP} sui_txst_t;
endpackage

// file: src/sui_brg.sv
// baud divider: selected source divided by the eight-bit value plus one
`timescale 1ns/1ps
module sui_brg #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // control
    input  wire logic         i_src_tick,
    input  wire logic [W-1:0] i_div,
    // output
    output logic              o_tick
);
    logic [W-1:0] cnt_q;

    if (W < 1) begin : g_bad_width
        $error("sui_brg: width must be positive");
    end

    // reload counter divides the source by value plus one
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q  <= '0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            if (i_src_tick) begin
                if (cnt_q == '0) begin
                    cnt_q  <= i_div;
                    o_tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule

// file: src/sui_sync.sv
// two stage synchroniser for pin inputs
`timescale 1ns/1ps
module sui_sync #(
    parameter int N = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // data
    input  wire logic [N-1:0] i_d,
    output logic      [N-1:0] o_q
);
    logic [N-1:0] s1_q;

    // two flops before any reader
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_q <= '1;
            o_q  <= '1;
        end else begin
            s1_q <= i_d;
            o_q  <= s1_q;
        end
    end
endmodule

// file: src/sui_core.sv
// one serial channel: uart engine plus basic i2c mode handling
`timescale 1ns/1ps
// Overview of operation
// - transmit line idles high or released
// - 7, 8 or 9 data bits used
// - uart bit rate is divider output over 16
// - receive enable toggle resets reception
// - mode disable then enable, with receive enabled, resets transmit buffer
// - msb-first only for 8-bit characters
// - data logic inversion on write and read
// - line polarity inverts all line bits
// - cts low needed; stop before next character
// - rts low when ready, high at clock fall
// - flow disable, else cts or rts type
// - channel 0 split cts input selection
// - transmit line high during receive only
// - i2c entered with mode 010 and select
// - sda changes only after scl stably low
// - i2c 8 bits, scl source over 2(n+1)
// - i2c transmit needs enable and data
// - i2c receive needs both enables and data
// - i2c start, stop, ack, nack events
// - overrun at 8th bit; no receive request
// - arbitration timing, sda delay, clock phase
module sui_core #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // configuration
    input  wire logic [2:0]       i_mode_field,
    input  wire logic             i_i2c_mode_select_bit,
    input  wire logic             i_clock_source_direction_bit,
    input  wire logic [DIV_W-1:0] i_baud_divider_reg,
    input  wire logic             i_src_tick,
    input  wire logic             i_bit_order_select,
    input  wire logic             i_data_logic_invert_bit,
    input  wire logic             i_line_polarity_invert_bit,
    input  wire logic             i_open_drain_select_bit,
    input  wire logic             i_flow_control_disable_bit,
    input  wire logic             i_flow_control_type_bit,
    input  wire logic             i_separate_cts_input_select,
    input  wire logic             i_clock_multiplex_bit,
    input  wire logic             i_abt_at_ninth,
    input  wire logic [3:0]       i_sda_delay,
    input  wire logic             i_clock_phase,
    // software access
    input  wire logic             i_transmit_enable_bit,
    input  wire logic             i_receive_enable_bit,
    input  wire logic             i_tx_write,
    input  wire logic [8:0]       i_tx_data,
    input  wire logic             i_rx_read,
    output logic [8:0]            o_receive_buffer_reg,
    output logic                  o_transmit_buffer_empty_flag,
    output logic                  o_rx_full,
    output logic                  o_overrun,
    output logic                  o_rx_irq,
    output logic                  o_start_irq,
    output logic                  o_stop_irq,
    output logic                  o_ack_irq,
    output logic                  o_nack_irq,
    output logic                  o_arbitration_lost_flag,
    // line pins
    input  wire logic             i_rxd,
    input  wire logic             i_sclk,
    input  wire logic             i_cts_pin,
    input  wire logic             i_cts_alt_pin,
    output logic                  o_txd,
    output logic                  o_txd_oe,
    output logic                  o_flow,
    output logic                  o_flow_oe,
    output logic                  o_scl,
    output logic                  o_scl_oe
);
    localparam logic [3:0] DLY_MAX = 4'(sui_pkg::MAX_DELAY);
    localparam logic [3:0] DLY_MIN = 4'(sui_pkg::MIN_DELAY);

    if (DIV_W != 8) begin : g_bad_div_width
        $error("sui_core: divider must be eight bits");
    end

    // ************************************************************
    // pin synchronisation and mode decode
    // ************************************************************
    logic [3:0] pin_s;
    logic       rxd_s, scl_s, cts_s, ctsa_s;
    sui_sync #(.N(4)) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_rxd, i_sclk, i_cts_pin, i_cts_alt_pin}),
        .o_q   (pin_s)
    );
    assign {rxd_s, scl_s, cts_s, ctsa_s} = pin_s;

    logic is_uart, is_i2c, uart8;
    logic [3:0] nbits;
    assign is_i2c  = (i_mode_field == sui_pkg::MODE_I2C) && i_i2c_mode_select_bit;
    assign is_uart = (i_mode_field == sui_pkg::MODE_UART7) ||
                     (i_mode_field == sui_pkg::MODE_UART8) ||
                     (i_mode_field == sui_pkg::MODE_UART9);
    assign uart8   = (i_mode_field == sui_pkg::MODE_UART8);
    assign nbits = (i_mode_field == sui_pkg::MODE_UART7) ? 4'(sui_pkg::LEN7) :
                   (i_mode_field == sui_pkg::MODE_UART9) ? 4'(sui_pkg::LEN9) :
                   4'(sui_pkg::LEN8);
    logic msb_first;
    assign msb_first = i_bit_order_select && (uart8 || is_i2c);

    // ************************************************************
    // bit rate
    // ************************************************************
    logic brg_tick;
    sui_brg #(.W(DIV_W)) u_brg (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_src_tick (i_src_tick),
        .i_div      (i_baud_divider_reg),
        .o_tick     (brg_tick)
    );
    logic [3:0] tx_ovs_q;
    logic       bit_tick;
    // sixteen divider ticks per uart bit
    always_ff @(posedge i_clk) begin
        if (i_rst) tx_ovs_q <= '0;
        else if (brg_tick) tx_ovs_q <= tx_ovs_q + 4'h1;
    end
    assign bit_tick = brg_tick && (tx_ovs_q == sui_pkg::OVS_LAST);

    // internal scl toggles on every divider tick: source over 2(n+1)
    logic scl_int_q;
    always_ff @(posedge i_clk) begin
        if (i_rst || !is_i2c) scl_int_q <= 1'b1;
        else if (brg_tick) scl_int_q <= ~scl_int_q;
    end
    logic scl_lvl, scl_prev_q, scl_fall, scl_rise;
    assign scl_lvl  = (i_clock_source_direction_bit == sui_pkg::CLK_INTERNAL) ? scl_int_q : scl_s;
    assign scl_fall = scl_prev_q && !scl_lvl;
    assign scl_rise = !scl_prev_q && scl_lvl;

    // ************************************************************
    // transmit buffer, with recovery sequence
    // ************************************************************
    logic [8:0] tbuf_q;
    logic       mode_off_seen_q;
    logic       tx_load;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tbuf_q          <= '0;
            o_transmit_buffer_empty_flag <= 1'b1;
            mode_off_seen_q <= 1'b0;
        end else begin
            if (i_mode_field == sui_pkg::MODE_OFF) mode_off_seen_q <= 1'b1;
            if (mode_off_seen_q && i_mode_field != sui_pkg::MODE_OFF &&
                i_rx_read == 1'b0 && i_receive_enable_bit) begin
                o_transmit_buffer_empty_flag <= 1'b1;
                mode_off_seen_q <= 1'b0;
            end else if (i_tx_write) begin
                tbuf_q      <= i_data_logic_invert_bit ? ~i_tx_data : i_tx_data;
                o_transmit_buffer_empty_flag <= 1'b0;
            end else if (tx_load) begin
                o_transmit_buffer_empty_flag <= 1'b1;
            end
        end
    end

    // ************************************************************
    // transmitter
    // ************************************************************
    sui_pkg::sui_txst_t tx_st_q;
    logic [8:0] tsh_q;
    logic [3:0] tcnt_q;
    logic       tx_line_q, cts_ok, cts_sel;
    assign cts_sel = i_separate_cts_input_select && !i_clock_multiplex_bit ? ctsa_s : cts_s;
    assign cts_ok  = i_flow_control_disable_bit ||
                     i_flow_control_type_bit == sui_pkg::FLOW_RTS || !cts_sel;
    // i2c starts only with transmit enabled and data waiting
    assign tx_load = (tx_st_q == sui_pkg::SUI_IDLE) && !o_transmit_buffer_empty_flag &&
                     i_transmit_enable_bit &&
                     ((is_uart && bit_tick && cts_ok) || (is_i2c && scl_fall));
    always_ff @(posedge i_clk) begin
        if (i_rst || (!is_uart && !is_i2c)) begin
            tx_st_q   <= sui_pkg::SUI_IDLE;
            tsh_q     <= '0;
            tcnt_q    <= '0;
            tx_line_q <= 1'b1;
        end else begin
            unique case (tx_st_q)
                sui_pkg::SUI_IDLE: begin
                    tx_line_q <= 1'b1;
                    if (tx_load) begin
                        tsh_q     <= tbuf_q;
                        tcnt_q    <= '0;
                        tx_st_q   <= is_i2c ? sui_pkg::SUI_DATA : sui_pkg::SUI_START;
                        tx_line_q <= is_i2c ? (msb_first ? tbuf_q[7] : tbuf_q[0]) : 1'b0;
                    end
                end
                sui_pkg::SUI_START: if (bit_tick) begin
                    tx_line_q <= msb_first ? tsh_q[7] : tsh_q[0];
                    tx_st_q   <= sui_pkg::SUI_DATA;
                end
                sui_pkg::SUI_DATA: if ((is_uart && bit_tick) || (is_i2c && scl_fall)) begin
                    tsh_q  <= msb_first ? {tsh_q[8], tsh_q[6:0], 1'b0} : {1'b0, tsh_q[8:1]};
                    tcnt_q <= tcnt_q + 4'h1;
                    if (tcnt_q == nbits - 4'h1) begin
                        tx_line_q <= 1'b1;
                        tx_st_q   <= is_i2c ? sui_pkg::SUI_IDLE : sui_pkg::SUI_STOP;
                    end else begin
                        tx_line_q <= msb_first ? tsh_q[6] : tsh_q[1];
                    end
                end
                sui_pkg::SUI_STOP: if (bit_tick) tx_st_q <= sui_pkg::SUI_IDLE;
            endcase
        end
    end

    // sda delay: hold change until scl has stayed low for the set count; settings below 2 do not hold, settings above 8 never release
    logic [3:0] sda_dly_q;
    logic       sda_q;
    always_ff @(posedge i_clk) begin
        if (i_rst || !is_i2c || scl_lvl) sda_dly_q <= '0;
        else if (i_src_tick && sda_dly_q != DLY_MAX) sda_dly_q <= sda_dly_q + 4'h1;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) sda_q <= 1'b1;
        else if (!scl_lvl && (i_sda_delay < DLY_MIN || sda_dly_q >= i_sda_delay) && !scl_fall)
            sda_q <= tx_line_q;
    end

    // line output with polarity inversion and open drain
    logic line_val;
    assign line_val = is_i2c ? sda_q : (tx_line_q ^ i_line_polarity_invert_bit);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_txd    <= 1'b1;
            o_txd_oe <= 1'b0;
        end else begin
            o_txd    <= line_val;
            o_txd_oe <= (is_uart || is_i2c) && !((i_open_drain_select_bit || is_i2c) && line_val);
        end
    end
    // scl drive as master, phase option inverts scl while the transmitter is idle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_scl    <= 1'b1;
            o_scl_oe <= 1'b0;
        end else begin
            o_scl    <= scl_int_q ^ (i_clock_phase && tx_st_q == sui_pkg::SUI_IDLE);
            o_scl_oe <= is_i2c && i_clock_source_direction_bit == sui_pkg::CLK_INTERNAL &&
                        !scl_int_q;
        end
    end

    // ************************************************************
    // receiver
    // ************************************************************
    logic       re_q, rx_busy_q, rxd_lvl, rx_first_q;
    logic [3:0] rovs_q, rcnt_q;
    logic [8:0] rsh_q;
    assign rxd_lvl = is_i2c ? rxd_s : (rxd_s ^ i_line_polarity_invert_bit);
    logic rx_samp, rx_done;
    assign rx_samp = is_uart ? (brg_tick && rovs_q == sui_pkg::OVS_MID) : scl_rise;
    assign rx_done = rx_busy_q && rx_samp && !rx_first_q && rcnt_q == nbits - 4'h1;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            re_q       <= 1'b0;
            scl_prev_q <= 1'b1;
        end else begin
            re_q       <= i_receive_enable_bit;
            scl_prev_q <= scl_lvl;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_receive_enable_bit || (!is_uart && !is_i2c)) begin
            rx_busy_q  <= 1'b0;
            rovs_q     <= '0;
            rcnt_q     <= '0;
            rsh_q      <= '0;
            rx_first_q <= 1'b0;
        end else if (!rx_busy_q) begin
            rovs_q <= '0;
            // i2c reception runs alongside an enabled, loaded transmit
            if ((is_uart && !rxd_lvl) || (is_i2c && tx_load)) begin
                rx_busy_q  <= 1'b1;
                rx_first_q <= is_uart;
                rcnt_q     <= '0;
            end
        end else begin
            if (brg_tick) rovs_q <= rovs_q + 4'h1;
            if (rx_samp) begin
                if (rx_first_q) rx_first_q <= 1'b0;
                else begin
                    rsh_q  <= msb_first ? {rsh_q[7:0], rxd_lvl} : {rxd_lvl, rsh_q[8:1]};
                    rcnt_q <= rcnt_q + 4'h1;
                    if (rcnt_q == nbits) rx_busy_q <= 1'b0; // held to the stop bit
                end
            end
        end
    end
    logic [8:0] rx_word;
    always_comb begin
        rx_word = msb_first ? {rsh_q[7:0], rxd_lvl} : {rxd_lvl, rsh_q[8:1]};
        if (!msb_first) rx_word = rx_word >> (4'(sui_pkg::LEN9) - nbits);
        if (nbits == 4'(sui_pkg::LEN7)) rx_word[8:7] = 2'h0;
        else if (nbits == 4'(sui_pkg::LEN8)) rx_word[8] = 1'b0;
    end

    // receive buffer, overrun and request
    logic [8:0] rbuf_q;
    always_ff @(posedge i_clk) begin
        if (i_rst || (re_q && !i_receive_enable_bit)) begin
            rbuf_q    <= '0;
            o_rx_full <= 1'b0;
            o_overrun <= 1'b0;
            o_rx_irq  <= 1'b0;
        end else begin
            o_rx_irq <= 1'b0;
            if (rx_done) begin
                rbuf_q <= rx_word;
                if (o_rx_full && !i_rx_read) o_overrun <= 1'b1;
                else o_rx_irq <= 1'b1;
                o_rx_full <= 1'b1;
            end else if (i_rx_read) begin
                o_rx_full <= 1'b0;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) o_receive_buffer_reg <= '0;
        else o_receive_buffer_reg <= i_data_logic_invert_bit ? ~rbuf_q : rbuf_q;
    end

    // ************************************************************
    // flow control pin
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_flow    <= 1'b1;
            o_flow_oe <= 1'b0;
        end else begin
            o_flow_oe <= !i_flow_control_disable_bit &&
                         i_flow_control_type_bit == sui_pkg::FLOW_RTS;
            if (scl_fall && rx_busy_q) o_flow <= 1'b1;
            else if (i_receive_enable_bit && !o_rx_full && !rx_busy_q) o_flow <= 1'b0;
        end
    end

    // ************************************************************
    // i2c bus events
    // ************************************************************
    logic sda_prev_q, ninth_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sda_prev_q              <= 1'b1;
            ninth_q                 <= 1'b0;
            o_start_irq             <= 1'b0;
            o_stop_irq              <= 1'b0;
            o_ack_irq               <= 1'b0;
            o_nack_irq              <= 1'b0;
            o_arbitration_lost_flag <= 1'b0;
        end else begin
            sda_prev_q  <= rxd_s;
            o_start_irq <= is_i2c && scl_s && sda_prev_q && !rxd_s;
            o_stop_irq  <= is_i2c && scl_s && !sda_prev_q && rxd_s;
            o_ack_irq   <= is_i2c && ninth_q && scl_rise && !rxd_s;
            o_nack_irq  <= is_i2c && ninth_q && scl_rise && rxd_s;
            if (is_i2c && rx_done) ninth_q <= 1'b1;
            else if (scl_rise) ninth_q <= 1'b0;
            // update at every bit or only at the ninth bit
            if (is_i2c && scl_rise && (!i_abt_at_ninth || ninth_q) &&
                tx_st_q == sui_pkg::SUI_DATA && sda_q && !rxd_s)
                o_arbitration_lost_flag <= 1'b1;
            else if (!is_i2c) o_arbitration_lost_flag <= 1'b0;
        end
    end
endmodule

// file: test/sui_peer.sv
// remote serial node model on the line side of the channel
`timescale 1ns/1ps
module sui_peer #(
    parameter int BIT = 32
) (
    // line pins
    input  wire logic i_clk,
    input  wire logic i_txd,
    output logic      o_rxd
);
    initial o_rxd = 1'h1;
    // sends start, n data bits lsb first, then a stop bit
    task automatic put(input logic [8:0] d, input int n, input logic pol);
        for (int k = -1; k <= n; k++) begin
            o_rxd = pol ^ ((k < 0) ? 1'h0 : (k == n) ? 1'h1 : d[k]);
            repeat (BIT) @(posedge i_clk);
            #1;
        end
    endtask
    // samples one frame at bit centres; unknown when missing or bad stop
    task automatic get(input int n, input logic pol, output logic [8:0] d);
        int t = 0;
        d = 'x;
        while (i_txd !== pol && t < 4000) begin
            @(posedge i_clk);
            t++;
        end
        if (t < 4000) begin
            d = '0;
            repeat (BIT / 2) @(posedge i_clk);
            for (int k = 0; k < n; k++) begin
                repeat (BIT) @(posedge i_clk);
                d[k] = i_txd ^ pol;
            end
            repeat (BIT) @(posedge i_clk);
            if (i_txd !== ~pol) d = 'x;
        end
    endtask
endmodule

// file: test/sui_core_assertions.sv
// port level checks of the serial channel
`timescale 1ns/1ps
module sui_core_chk (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst,
    // configuration
    input wire logic [2:0] i_mode_field,
    input wire logic       i_transmit_enable_bit,
    input wire logic       i_receive_enable_bit,
    input wire logic       i_line_polarity_invert_bit,
    input wire logic       i_open_drain_select_bit,
    input wire logic       i_flow_control_disable_bit,
    input wire logic       i_flow_control_type_bit,
    // outputs watched
    input wire logic       o_rx_full,
    input wire logic       o_overrun,
    input wire logic       o_rx_irq,
    input wire logic       o_txd,
    input wire logic       o_flow_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // decoded settings
    wire logic uart    = i_mode_field[2];
    wire logic cts_sel = !i_flow_control_disable_bit && !i_flow_control_type_bit;
    wire logic rts_sel = !i_flow_control_disable_bit && i_flow_control_type_bit;
    wire logic rx_only = uart && !i_transmit_enable_bit && !i_line_polarity_invert_bit
                         && !i_open_drain_select_bit;
    // ********
    // assertions
    // ********
    a_reset_line_idle:
        assert property ($fell(i_rst) |-> o_txd && !o_rx_full && !o_overrun)
        else $error("line or flags wrong after reset");
    a_gpio_flow_pin:
        assert property (i_flow_control_disable_bit [*3] |-> !o_flow_oe)
        else $error("flow pin driven while disabled");
    a_cts_pin_input:
        assert property (cts_sel [*3] |-> !o_flow_oe)
        else $error("flow pin driven as cts input");
    a_rts_pin_output:
        assert property ((rts_sel && uart) [*3] |-> o_flow_oe)
        else $error("rts pin not driven");
    a_receive_only_idle:
        assert property (rx_only [*4] |-> o_txd)
        else $error("transmit line low in receive only");
    a_overrun_needs_full:
        assert property ($rose(o_overrun) |-> $past(o_rx_full))
        else $error("overrun without unread buffer");
    a_overrun_no_irq:
        assert property ($rose(o_overrun) |-> !o_rx_irq)
        else $error("receive request on overrun");
    a_enable_drop_flush:
        assert property ($fell(i_receive_enable_bit) |-> ##2 !o_rx_full && !o_overrun)
        else $error("receive state kept after enable drop");
endmodule
bind sui_core sui_core_chk u_chk (.i_clk, .i_rst, .i_mode_field, .i_transmit_enable_bit,
    .i_receive_enable_bit, .i_line_polarity_invert_bit, .i_open_drain_select_bit,
    .i_flow_control_disable_bit, .i_flow_control_type_bit, .o_rx_full, .o_overrun,
    .o_rx_irq, .o_txd, .o_flow_oe);

// file: test/sui_core_test.sv
// self-checking bench for the serial channel in uart mode
`timescale 1ns/1ps
module sui_core_test;
    // ********
    // signals
    // ********
    logic       i_clk = 0, i_rst = 1, i_src_tick = 0, i_tx_write = 0, i_rx_read = 0;
    logic [2:0] i_mode_field = sui_pkg::MODE_UART8;
    logic [7:0] i_baud_divider_reg = 8'h00;
    logic [3:0] i_sda_delay = 4'h0;
    logic [8:0] i_tx_data = 9'h000, o_receive_buffer_reg, got;
    logic       i_i2c_mode_select_bit = 0, i_clock_source_direction_bit = 0;
    logic       i_bit_order_select = 0, i_data_logic_invert_bit = 0;
    logic       i_line_polarity_invert_bit = 0, i_open_drain_select_bit = 0;
    logic       i_flow_control_disable_bit = 1, i_flow_control_type_bit = 0;
    logic       i_separate_cts_input_select = 0, i_clock_multiplex_bit = 0;
    logic       i_abt_at_ninth = 0, i_clock_phase = 0, i_sclk = 1;
    logic       i_transmit_enable_bit = 1, i_receive_enable_bit = 0;
    logic       i_cts_pin = 0, i_cts_alt_pin = 1, i_rxd, o_txd, o_txd_oe, o_flow, o_flow_oe;
    logic       o_transmit_buffer_empty_flag, o_rx_full, o_overrun;
    int         fails = 0, total_checks = 0;
    // clock and count source every other cycle: 32 cycles a bit
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) i_src_tick <= #1 ~i_src_tick;
    sui_core u_dut (.i_clk, .i_rst, .i_mode_field, .i_i2c_mode_select_bit,
        .i_clock_source_direction_bit, .i_baud_divider_reg, .i_src_tick, .i_bit_order_select,
        .i_data_logic_invert_bit, .i_line_polarity_invert_bit, .i_open_drain_select_bit,
        .i_flow_control_disable_bit, .i_flow_control_type_bit, .i_separate_cts_input_select,
        .i_clock_multiplex_bit, .i_abt_at_ninth, .i_sda_delay, .i_clock_phase,
        .i_transmit_enable_bit, .i_receive_enable_bit, .i_tx_write, .i_tx_data, .i_rx_read,
        .o_receive_buffer_reg, .o_transmit_buffer_empty_flag, .o_rx_full, .o_overrun,
        .o_rx_irq(), .o_start_irq(), .o_stop_irq(), .o_ack_irq(), .o_nack_irq(),
        .o_arbitration_lost_flag(), .i_rxd, .i_sclk, .i_cts_pin, .i_cts_alt_pin, .o_txd,
        .o_txd_oe, .o_flow, .o_flow_oe, .o_scl(), .o_scl_oe());
    sui_peer #(.BIT(32)) u_peer (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(i_rxd));
    // ********
    // tasks
    // ********
    task automatic step;
        @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [8:0] d);
        i_tx_data = d;
        i_tx_write = 1;
        step;
        i_tx_write = 0;
    endtask
    // far side takes one character, then the stop bit ends
    task automatic fetch(input int n, input logic [8:0] exp);
        u_peer.get(n, i_line_polarity_invert_bit, got);
        chk(got, exp);
        repeat (24) step;
    endtask
    // far side sends one character and the buffer is read back
    task automatic rcv(input logic [8:0] d, input int n, input logic [8:0] exp);
        int t = 0;
        u_peer.put(d, n, 1'h0);
        while (o_rx_full !== 1'h1 && t < 64) begin
            step;
            t++;
        end
        step;
        chk(o_receive_buffer_reg, exp);
        i_rx_read = 1;
        step;
        i_rx_read = 0;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        end_sim;
    end
    // ********
    // tests
    // ********
    initial begin
        repeat (4) step;
        i_rst = 0;
        repeat (3) step;
        chk(o_txd, 1'h1);
        chk(o_flow_oe, 1'h0);
        i_open_drain_select_bit = 1;
        repeat (3) step;
        chk(o_txd_oe, 1'h0);
        i_open_drain_select_bit = 0;
        $display("test idle done");
        wr(9'h0A5);
        fetch(8, 9'h0A5);
        i_bit_order_select = 1;
        wr(9'h001);
        fetch(8, 9'h080);
        i_mode_field = sui_pkg::MODE_UART7;
        wr(9'h041);
        fetch(7, 9'h041);
        i_mode_field = sui_pkg::MODE_UART9;
        wr(9'h1A5);
        fetch(9, 9'h1A5);
        i_mode_field = sui_pkg::MODE_UART8;
        i_bit_order_select = 0;
        i_data_logic_invert_bit = 1;
        wr(9'h00F);
        fetch(8, 9'h0F0);
        i_data_logic_invert_bit = 0;
        i_line_polarity_invert_bit = 1;
        repeat (3) step;
        chk(o_txd, 1'h0);
        i_cts_pin = 1;
        wr(9'h03C);
        fetch(8, 9'h03C);
        i_line_polarity_invert_bit = 0;
        $display("test transmit done");
        i_flow_control_disable_bit = 0;
        wr(9'h055);
        repeat (100) step;
        chk({o_txd, o_transmit_buffer_empty_flag}, 2'h2);
        i_cts_pin = 0;
        fetch(8, 9'h055);
        i_cts_pin = 1;
        i_separate_cts_input_select = 1;
        i_cts_alt_pin = 0;
        wr(9'h033);
        fetch(8, 9'h033);
        i_separate_cts_input_select = 0;
        wr(9'h066);
        chk(o_transmit_buffer_empty_flag, 1'h0);
        i_mode_field = sui_pkg::MODE_OFF;
        step;
        i_mode_field = sui_pkg::MODE_UART8;
        step;
        i_receive_enable_bit = 1;
        repeat (4) step;
        chk(o_transmit_buffer_empty_flag, 1'h1);
        i_flow_control_disable_bit = 1;
        $display("test flow done");
        i_transmit_enable_bit = 0;
        rcv(9'h05A, 8, 9'h05A);
        i_mode_field = sui_pkg::MODE_UART7;
        rcv(9'h0FF, 7, 9'h07F);
        i_mode_field = sui_pkg::MODE_UART9;
        rcv(9'h1C3, 9, 9'h1C3);
        i_mode_field = sui_pkg::MODE_UART8;
        i_data_logic_invert_bit = 1;
        rcv(9'h00F, 8, 9'h1F0);
        i_data_logic_invert_bit = 0;
        chk(o_txd, 1'h1);
        u_peer.put(9'h011, 8, 1'h0);
        u_peer.put(9'h022, 8, 1'h0);
        chk(o_overrun, 1'h1);
        i_receive_enable_bit = 0;
        step;
        i_receive_enable_bit = 1;
        repeat (3) step;
        chk({o_rx_full, o_overrun}, 2'h0);
        i_flow_control_disable_bit = 0;
        i_flow_control_type_bit = 1;
        repeat (4) step;
        chk({o_flow_oe, o_flow}, 2'h2);
        $display("test receive done");
        end_sim;
    end
endmodule
